/* File: design/sfcfe_defines.svh */
// Constants of the serial command front end: op-codes, status layout,
// reset values and input synchroniser depth.
// Assumes inclusion by bare name from design and bench files.
`ifndef SFCFE_DEFINES_SVH
`define SFCFE_DEFINES_SVH

// Op-code byte values
`define SFCFE_OP_SET_LATCH   8'h06
`define SFCFE_OP_CLR_LATCH   8'h04
`define SFCFE_OP_STAT_READ   8'h05
`define SFCFE_OP_STAT_WRITE  8'h01
`define SFCFE_OP_MEM_READ    8'h03
`define SFCFE_OP_MEM_WRITE   8'h02

// Status byte bit positions
`define SFCFE_ST_PIN_LOCK    7
`define SFCFE_ST_BP_HI       3
`define SFCFE_ST_BP_LO       2
`define SFCFE_ST_LATCH       1

// Reset values
`define SFCFE_RST_LATCH      1'b0
`define SFCFE_RST_PROTECT    1'b0
// Idle pin levels {cs_n, sck, si, wp_n}: deselected, clock low, unprotected
`define SFCFE_RST_PINS       4'h9

// Bit index of the last bit of a byte
`define SFCFE_LAST_BIT       3'h7

// Synchroniser stages on pin inputs
`define SFCFE_SYNC_STAGES    2

`endif

/* File: design/sfcfe_pkg.sv */
// Types shared by the serial command front end.
// Assumes sfcfe_defines.svh holds the numeric constants.
package sfcfe_pkg;

    // Decoded command of the current selection
    typedef enum logic [2:0] {
        CMD_NONE,
        CMD_SET_LATCH,
        CMD_CLR_LATCH,
        CMD_STAT_READ,
        CMD_STAT_WRITE,
        CMD_MEM_READ,
        CMD_MEM_WRITE,
        CMD_UNKNOWN
    } sfcfe_cmd_t;

    // Frame sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_OPCODE,
        ST_ADDR_HI,
        ST_ADDR_LO,
        ST_DATA,
        ST_STAT_OUT,
        ST_STAT_IN,
        ST_IGNORE
    } sfcfe_state_t;

    // Serial pins arriving from the master
    typedef struct packed {
        logic cs_n;
        logic sck;
        logic si;
        logic wp_n;
    } sfcfe_pins_t;

    // Status byte fields held by the device
    typedef struct packed {
        logic pin_lock_enable;
        logic block_protect_hi;
        logic block_protect_lo;
        logic write_latch_flag;
    } sfcfe_status_t;

endpackage : sfcfe_pkg

/* File: design/sfcfe_sync.sv */
// Two-flop synchroniser bank for asynchronous pin inputs.
// Assumes each bit is an independent level from outside clk_sys.
`timescale 1ns/100ps
`include "sfcfe_defines.svh"
module sfcfe_sync #(
    parameter int               WIDTH   = 4,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             nrst,
    // Raw and synchronised levels
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);

    // ----------------------------------------
    // Per-bit flop chain
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            logic [`SFCFE_SYNC_STAGES-1:0] chain_r; // Stage 0 feeds only stage 1
            always_ff @(posedge clk_sys) begin
                if (!nrst) begin
                    chain_r <= {`SFCFE_SYNC_STAGES{RST_VAL[gi]}}; // Idle level, no false edge
                end else begin
                    chain_r <= {chain_r[`SFCFE_SYNC_STAGES-2:0], din[gi]};
                end
            end
            assign dout[gi] = chain_r[`SFCFE_SYNC_STAGES-1];
        end
    endgenerate

endmodule : sfcfe_sync

/* File: design/sfcfe_core.sv */
// Serial slave command front end of a 2,048 x 8 nonvolatile RAM.
// Assumes an SPI master on the pins, slow enough to be sampled by clk_sys.
`timescale 1ns/100ps
`include "sfcfe_defines.svh"
module sfcfe_core #(
    parameter int ADDR_W = 11
) (
    // Clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  nrst,
    // Serial pins from the master
    input  wire sfcfe_pkg::sfcfe_pins_t pins,
    output logic                       so_o,
    output logic                       so_oe,
    // Decoded command and address
    output sfcfe_pkg::sfcfe_cmd_t      cmd_o,
    output logic [ADDR_W-1:0]          addr_o,
    output logic                       addr_valid_o,
    output logic                       mode3_o,
    // Memory write byte stream
    output logic [7:0]                 wr_byte_o,
    output logic                       wr_valid_o,
    // Status bits
    output sfcfe_pkg::sfcfe_status_t   status_o
);

    // ----------------------------------------
    // Pin synchronisation and edge detection
    // ----------------------------------------
    sfcfe_pkg::sfcfe_pins_t  pins_s;      // Synchronised pins
    logic                    sck_d;       // Previous clock level
    logic                    cs_d;        // Previous select level
    logic                    sck_rise;    // Serial clock rising
    logic                    sck_fall;    // Serial clock falling
    logic                    cs_fall;     // Select asserted
    logic                    cs_rise;     // Select released

    sfcfe_sync #(.WIDTH(4), .RST_VAL(`SFCFE_RST_PINS)) u_sync (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .din     (pins),
        .dout    (pins_s)
    );

    // Delayed copies for edges
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            sck_d <= 1'b0;
            cs_d  <= 1'b1;
        end else begin
            sck_d <= pins_s.sck;
            cs_d  <= pins_s.cs_n;
        end
    end

    assign sck_rise = !pins_s.cs_n && pins_s.sck && !sck_d;
    assign sck_fall = !pins_s.cs_n && !pins_s.sck && sck_d;
    assign cs_fall  = cs_d && !pins_s.cs_n;
    assign cs_rise  = !cs_d && pins_s.cs_n;

    // ----------------------------------------
    // Receive shifter
    // ----------------------------------------
    sfcfe_pkg::sfcfe_state_t state_r;     // Frame sequencer
    logic [2:0]              bit_cnt_r;   // Bit within byte
    logic [6:0]              rx_sh_r;     // Bits taken so far
    logic [7:0]              rx_byte;     // Byte incl. current bit
    logic                    byte_done;   // Eighth rising edge

    assign rx_byte   = {rx_sh_r, pins_s.si};
    assign byte_done = sck_rise && (bit_cnt_r == `SFCFE_LAST_BIT);

    // Shift in on rising edges, MSB first
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            bit_cnt_r <= 3'h0;
            rx_sh_r   <= 7'h00;
        end else if (pins_s.cs_n || cs_fall) begin
            bit_cnt_r <= 3'h0;
        end else if (sck_rise) begin
            bit_cnt_r <= bit_cnt_r + 3'h1;
            rx_sh_r   <= rx_byte[6:0];
        end
    end

    // ----------------------------------------
    // Op-code decode
    // ----------------------------------------
    sfcfe_pkg::sfcfe_cmd_t   opc;         // Decoded current byte
    logic                    opc_done;    // Op-code byte complete

    // Table decode of the byte just completed
    always_comb begin
        if (rx_byte == `SFCFE_OP_SET_LATCH) begin
            opc = sfcfe_pkg::CMD_SET_LATCH;
        end else if (rx_byte == `SFCFE_OP_CLR_LATCH) begin
            opc = sfcfe_pkg::CMD_CLR_LATCH;
        end else if (rx_byte == `SFCFE_OP_STAT_READ) begin
            opc = sfcfe_pkg::CMD_STAT_READ;
        end else if (rx_byte == `SFCFE_OP_STAT_WRITE) begin
            opc = sfcfe_pkg::CMD_STAT_WRITE;
        end else if (rx_byte == `SFCFE_OP_MEM_READ) begin
            opc = sfcfe_pkg::CMD_MEM_READ;
        end else if (rx_byte == `SFCFE_OP_MEM_WRITE) begin
            opc = sfcfe_pkg::CMD_MEM_WRITE;
        end else begin
            opc = sfcfe_pkg::CMD_UNKNOWN;
        end
    end

    assign opc_done = byte_done && (state_r == sfcfe_pkg::ST_OPCODE);

    // ----------------------------------------
    // Frame sequencer
    // ----------------------------------------
    logic                    stat_wr_done; // Status byte received

    assign stat_wr_done = byte_done && (state_r == sfcfe_pkg::ST_STAT_IN);

    // One op-code per selection, operands follow it
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            state_r <= sfcfe_pkg::ST_IDLE;
        end else if (pins_s.cs_n) begin
            state_r <= sfcfe_pkg::ST_IDLE;
        end else if (cs_fall) begin
            state_r <= sfcfe_pkg::ST_OPCODE;
        end else if (byte_done) begin
            case (state_r)
                sfcfe_pkg::ST_OPCODE: begin
                    case (opc)
                        sfcfe_pkg::CMD_STAT_READ:  state_r <= sfcfe_pkg::ST_STAT_OUT;
                        sfcfe_pkg::CMD_STAT_WRITE: state_r <= sfcfe_pkg::ST_STAT_IN;
                        sfcfe_pkg::CMD_MEM_READ,
                        sfcfe_pkg::CMD_MEM_WRITE:  state_r <= sfcfe_pkg::ST_ADDR_HI;
                        default:                   state_r <= sfcfe_pkg::ST_IGNORE;
                    endcase
                end
                sfcfe_pkg::ST_ADDR_HI: state_r <= sfcfe_pkg::ST_ADDR_LO;
                sfcfe_pkg::ST_ADDR_LO: state_r <= sfcfe_pkg::ST_DATA;
                sfcfe_pkg::ST_STAT_IN: state_r <= sfcfe_pkg::ST_IGNORE;
                default:               state_r <= state_r;
            endcase
        end
    end

    // Command and mode capture
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            cmd_o   <= sfcfe_pkg::CMD_NONE;
            mode3_o <= 1'b0;
        end else if (cs_fall) begin
            cmd_o   <= sfcfe_pkg::CMD_NONE;
            mode3_o <= pins_s.sck;
        end else if (opc_done) begin
            cmd_o   <= opc;
        end
    end

    // ----------------------------------------
    // Address capture
    // ----------------------------------------
    // Upper five address bits fall away
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            addr_o       <= '0;
            addr_valid_o <= 1'b0;
        end else begin
            addr_valid_o <= 1'b0;
            if (byte_done && state_r == sfcfe_pkg::ST_ADDR_HI) begin
                addr_o[ADDR_W-1:8] <= rx_byte[ADDR_W-9:0];
            end else if (byte_done && state_r == sfcfe_pkg::ST_ADDR_LO) begin
                addr_o[7:0]  <= rx_byte;
                addr_valid_o <= 1'b1;
            end
        end
    end

    // Memory write bytes leave at the eighth clock
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            wr_byte_o  <= 8'h00;
            wr_valid_o <= 1'b0;
        end else begin
            wr_valid_o <= byte_done && state_r == sfcfe_pkg::ST_DATA &&
                          cmd_o == sfcfe_pkg::CMD_MEM_WRITE &&
                          status_o.write_latch_flag;
            if (byte_done) begin
                wr_byte_o <= rx_byte;
            end
        end
    end

    // ----------------------------------------
    // Write latch and status bits
    // ----------------------------------------
    logic                    stat_locked; // Status write refused
    logic                    latch_r;     // Write enable latch
    logic                    lock_en_r;   // Pin lock enable bit
    logic                    bp_hi_r;     // Upper block protect bit
    logic                    bp_lo_r;     // Lower block protect bit

    // One driver per field, gathered into the status port
    assign status_o    = {lock_en_r, bp_hi_r, bp_lo_r, latch_r};
    assign stat_locked = status_o.pin_lock_enable && !pins_s.wp_n;

    // Latch set, cleared by command, status write, or deselect after a memory or status write op-code
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            latch_r <= `SFCFE_RST_LATCH;
        end else if (opc_done && opc == sfcfe_pkg::CMD_SET_LATCH) begin
            latch_r <= 1'b1;
        end else if (opc_done && opc == sfcfe_pkg::CMD_CLR_LATCH) begin
            latch_r <= 1'b0;
        end else if (stat_wr_done) begin
            latch_r <= 1'b0;
        end else if (cs_rise && (cmd_o == sfcfe_pkg::CMD_MEM_WRITE ||
                                 cmd_o == sfcfe_pkg::CMD_STAT_WRITE)) begin
            latch_r <= 1'b0;
        end
    end

    // Protection bits, written only when permitted
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            lock_en_r <= `SFCFE_RST_PROTECT;
            bp_hi_r   <= `SFCFE_RST_PROTECT;
            bp_lo_r   <= `SFCFE_RST_PROTECT;
        end else if (stat_wr_done && status_o.write_latch_flag && !stat_locked) begin
            lock_en_r <= rx_byte[`SFCFE_ST_PIN_LOCK];
            bp_hi_r   <= rx_byte[`SFCFE_ST_BP_HI];
            bp_lo_r   <= rx_byte[`SFCFE_ST_BP_LO];
        end
    end

    // ----------------------------------------
    // Status read output
    // ----------------------------------------
    logic [7:0]              stat_byte;   // Assembled status byte
    logic [7:0]              tx_sh_r;     // Bits still to send

    // Fixed zeros in bits 0 and 4 to 6
    always_comb begin
        stat_byte                     = 8'h00;
        stat_byte[`SFCFE_ST_PIN_LOCK] = status_o.pin_lock_enable;
        stat_byte[`SFCFE_ST_BP_HI]    = status_o.block_protect_hi;
        stat_byte[`SFCFE_ST_BP_LO]    = status_o.block_protect_lo;
        stat_byte[`SFCFE_ST_LATCH]    = status_o.write_latch_flag;
    end

    // Drive on falling edges, release when deselected
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            tx_sh_r <= 8'h00;
            so_o    <= 1'b0;
            so_oe   <= 1'b0;
        end else if (pins_s.cs_n) begin
            so_oe   <= 1'b0;
        end else if (opc_done && opc == sfcfe_pkg::CMD_STAT_READ) begin
            tx_sh_r <= stat_byte;
        end else if (sck_fall && state_r == sfcfe_pkg::ST_STAT_OUT) begin
            so_o    <= tx_sh_r[7];
            so_oe   <= 1'b1;
            tx_sh_r <= (bit_cnt_r == `SFCFE_LAST_BIT) ? stat_byte : {tx_sh_r[6:0], 1'b0};
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    AST_RESET_LATCH: assert property (@(posedge clk_sys) !nrst |=> !status_o.write_latch_flag)
        else $error("Latch not clear after reset");
    AST_SET_LATCH: assert property (@(posedge clk_sys) disable iff (!nrst)
        opc_done && opc == sfcfe_pkg::CMD_SET_LATCH |=> status_o.write_latch_flag)
        else $error("Set command did not set latch");
    AST_CLR_LATCH: assert property (@(posedge clk_sys) disable iff (!nrst)
        opc_done && opc == sfcfe_pkg::CMD_CLR_LATCH |=> !status_o.write_latch_flag)
        else $error("Clear command did not clear latch");
    AST_STAT_WR_CLEARS: assert property (@(posedge clk_sys) disable iff (!nrst)
        stat_wr_done |=> !status_o.write_latch_flag)
        else $error("Status write left latch set");
    AST_DESELECT_CLEARS: assert property (@(posedge clk_sys) disable iff (!nrst)
        cs_rise && cmd_o == sfcfe_pkg::CMD_MEM_WRITE |=> !status_o.write_latch_flag)
        else $error("Write deselect left latch set");
    AST_LOCKED_STABLE: assert property (@(posedge clk_sys) disable iff (!nrst)
        stat_wr_done && stat_locked |=> $stable(status_o.block_protect_hi) && $stable(status_o.block_protect_lo))
        else $error("Locked status changed");
    AST_MODE_CAPTURE: assert property (@(posedge clk_sys) disable iff (!nrst)
        cs_fall |=> mode3_o == $past(pins_s.sck))
        else $error("Mode not taken at select fall");
    AST_RELEASE: assert property (@(posedge clk_sys) disable iff (!nrst)
        pins_s.cs_n [*2] |-> !so_oe)
        else $error("Output driven while deselected");
    AST_DRIVE_ON_FALL: assert property (@(posedge clk_sys) disable iff (!nrst)
        so_oe && $changed(so_o) |-> $past(sck_fall))
        else $error("Output changed off a falling edge");
    AST_UNKNOWN_QUIET: assert property (@(posedge clk_sys) disable iff (!nrst)
        state_r == sfcfe_pkg::ST_IGNORE && cmd_o == sfcfe_pkg::CMD_UNKNOWN |-> !so_oe && !wr_valid_o)
        else $error("Unknown op-code caused action");
    AST_ADDR_PULSE: assert property (@(posedge clk_sys) disable iff (!nrst)
        addr_valid_o |-> addr_o[7:0] == $past(rx_byte))
        else $error("Address low byte mismatch");

    COV_SET_LATCH: cover property (@(posedge clk_sys) opc_done && opc == sfcfe_pkg::CMD_SET_LATCH);
    COV_STAT_READ: cover property (@(posedge clk_sys) so_oe && sck_fall);
    COV_STAT_WRITE: cover property (@(posedge clk_sys) stat_wr_done && status_o.write_latch_flag);
    COV_MEM_WRITE: cover property (@(posedge clk_sys) wr_valid_o);

endmodule : sfcfe_core

/* File: tb/sfcfe_spi_master_model.sv */
// Behavioural serial bus master facing the command front end.
// Assumes calls from the bench at falling clk_sys edges; sck half period 4 cycles.
`timescale 1ns/100ps
module sfcfe_spi_master_model (
    // Reference clock
    input  wire logic              clk_sys,
    // Pins towards the device
    output sfcfe_pkg::sfcfe_pins_t pins,
    input  wire logic              so_o,
    input  wire logic              so_oe
);
    // ----------------------------------------
    // State and watchers
    // ----------------------------------------
    logic mode3_r;  // Idle clock level of open frame
    int   cs_hi;    // Cycles since select went high
    int   oe_idle;  // Output driven while deselected
    int   oe_hits;  // Output driven at all

    // Idle pins before reset ends
    initial begin
        pins    = '{cs_n: 1'b1, sck: 1'b0, si: 1'b1, wp_n: 1'b1};
        mode3_r = 1'b0;
        cs_hi   = 0;
        oe_idle = 0;
        oe_hits = 0;
    end

    // Count driven output, idle and in frame
    always @(posedge clk_sys) begin
        cs_hi = (pins.cs_n === 1'b1) ? cs_hi + 1 : 0;
        if (so_oe === 1'b1) begin
            oe_hits = oe_hits + 1;
            if (cs_hi > 4) begin
                oe_idle = oe_idle + 1;
            end
        end
    end

    // ----------------------------------------
    // Bus tasks
    // ----------------------------------------
    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : wait_clk

    // Protect pin level
    task automatic set_wp(input logic lvl);
        pins.wp_n = lvl;
    endtask : set_wp

    // Select low with clock at mode idle level
    task automatic begin_frame(input logic mode3);
        mode3_r  = mode3;
        pins.sck = mode3;
        wait_clk(4);
        pins.cs_n = 1'b0;
        wait_clk(4);
    endtask : begin_frame

    // One byte, MSB first; reads back only while driven
    task automatic xfer_byte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            pins.sck = 1'b0;
            pins.si  = tx[i];
            wait_clk(4);
            pins.sck = 1'b1;
            wait_clk(2);
            rx[i] = (so_oe === 1'b1) ? so_o : 1'bx;
            wait_clk(2);
        end
    endtask : xfer_byte

    // Clock back to idle, select high, data line toggled
    task automatic end_frame();
        pins.sck = mode3_r;
        wait_clk(4);
        pins.cs_n = 1'b1;
        pins.si   = ~pins.si;
        wait_clk(6);
    endtask : end_frame
endmodule : sfcfe_spi_master_model

/* File: tb/spi_fram_command_front_end_tb_top.sv */
// Self-checking bench of the serial command front end.
// Assumes the master model file compiles first.
`timescale 1ns/100ps
`include "sfcfe_defines.svh"
module spi_fram_command_front_end_tb_top;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic                     clk_sys;       // 125 MHz
    logic                     nrst;          // Sync reset, low
    sfcfe_pkg::sfcfe_pins_t   pins;          // Master pins
    logic                     so_o;          // Serial out
    logic                     so_oe;         // Serial out enable
    sfcfe_pkg::sfcfe_cmd_t    cmd_o;         // Decoded command
    logic [10:0]              addr_o;        // Captured address
    logic                     addr_valid_o;  // Address pulse
    logic                     mode3_o;       // Mode at select fall
    logic [7:0]               wr_byte_o;     // Received byte
    logic                     wr_valid_o;    // Write byte pulse
    sfcfe_pkg::sfcfe_status_t status_o;      // Status fields
    int                       fail_count;
    int                       check_count;
    int                       av_cnt;        // Address pulses
    int                       wv_cnt;        // Write pulses
    logic [7:0]               wv_byte;       // Last strobed byte
    logic [7:0]               rx;

    sfcfe_core i_sfcfe_core (.clk_sys(clk_sys), .nrst(nrst), .pins(pins), .so_o(so_o), .so_oe(so_oe),
        .cmd_o(cmd_o), .addr_o(addr_o), .addr_valid_o(addr_valid_o), .mode3_o(mode3_o),
        .wr_byte_o(wr_byte_o), .wr_valid_o(wr_valid_o), .status_o(status_o));
    sfcfe_spi_master_model i_sfcfe_spi_master_model (.clk_sys(clk_sys), .pins(pins), .so_o(so_o),
        .so_oe(so_oe));

    // Clock
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // Pulse counters
    always @(posedge clk_sys) begin
        if (addr_valid_o === 1'b1) begin
            av_cnt = av_cnt + 1;
        end
        if (wr_valid_o === 1'b1) begin
            wv_cnt  = wv_cnt + 1;
            wv_byte = wr_byte_o;
        end
    end

    // ----------------------------------------
    // Compare and bus tasks
    // ----------------------------------------
    task automatic chk_val(input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : chk_val

    task automatic chk_cmd(input sfcfe_pkg::sfcfe_cmd_t exp, input sfcfe_pkg::sfcfe_cmd_t got);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : chk_cmd

    // One selection of n bytes taken from the top of tx
    task automatic run_frame(input logic md, input logic [31:0] tx, input int n);
        i_sfcfe_spi_master_model.begin_frame(md);
        for (int k = 0; k < n; k++) begin
            i_sfcfe_spi_master_model.xfer_byte(tx[31-8*k -: 8], rx);
        end
        i_sfcfe_spi_master_model.end_frame();
    endtask : run_frame

    // Status read in mode 0, compared with expectation
    task automatic rd_st(input logic [7:0] exp);
        run_frame(1'b0, {`SFCFE_OP_STAT_READ, 24'h0}, 2);
        chk_val({8'h00, exp}, {8'h00, rx});
    endtask : rd_st

    task automatic set_latch();
        run_frame(1'b1, {`SFCFE_OP_SET_LATCH, 24'h0}, 1);
    endtask : set_latch

    // Verdict
    task automatic complete_run();
        $display("Checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run

    // Watchdog
    initial begin
        repeat (20000) @(posedge clk_sys);
        fail_count++;
        complete_run();
    end

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        nrst = 1'b0;
        fail_count = 0;
        check_count = 0;
        av_cnt = 0;
        wv_cnt = 0;
        wv_byte = 8'h00;
        repeat (3) @(negedge clk_sys);
        nrst = 1'b1;
        @(negedge clk_sys);
        rd_st(8'h00);
        chk_cmd(sfcfe_pkg::CMD_STAT_READ, cmd_o);
        chk_val(16'h0000, {15'h0, mode3_o});
        set_latch();
        chk_cmd(sfcfe_pkg::CMD_SET_LATCH, cmd_o);
        chk_val(16'h0001, {15'h0, mode3_o});
        rd_st(8'h02);
        run_frame(1'b0, {`SFCFE_OP_CLR_LATCH, 8'h06, 16'h0}, 2);
        chk_cmd(sfcfe_pkg::CMD_CLR_LATCH, cmd_o);
        rd_st(8'h00);
        // Status write without latch is refused
        run_frame(1'b0, {`SFCFE_OP_STAT_WRITE, 8'hff, 16'h0}, 2);
        chk_cmd(sfcfe_pkg::CMD_STAT_WRITE, cmd_o);
        rd_st(8'h00);
        set_latch();
        run_frame(1'b1, {`SFCFE_OP_STAT_WRITE, 8'hff, 16'h0}, 2);
        rd_st(8'h8c);
        chk_val(16'h000e, {12'h000, status_o});
        // Lock set and pin low: status write blocked
        i_sfcfe_spi_master_model.set_wp(1'b0);
        set_latch();
        run_frame(1'b0, {`SFCFE_OP_STAT_WRITE, 8'h00, 16'h0}, 2);
        rd_st(8'h8c);
        // Pin low never blocks the array
        set_latch();
        run_frame(1'b0, {`SFCFE_OP_MEM_WRITE, 8'hfd, 8'h5a, 8'h3c}, 4);
        chk_cmd(sfcfe_pkg::CMD_MEM_WRITE, cmd_o);
        chk_val(16'h055a, {5'h00, addr_o});
        chk_val(16'h0101, {av_cnt[7:0], wv_cnt[7:0]});
        chk_val(16'h003c, {8'h00, wv_byte});
        rd_st(8'h8c);
        // Memory write without latch gives no strobe
        run_frame(1'b1, {`SFCFE_OP_MEM_WRITE, 8'h00, 8'h07, 8'h99}, 4);
        chk_val(16'h0201, {av_cnt[7:0], wv_cnt[7:0]});
        // Pin high: lock ignored
        i_sfcfe_spi_master_model.set_wp(1'b1);
        set_latch();
        run_frame(1'b1, {`SFCFE_OP_STAT_WRITE, 8'h00, 16'h0}, 2);
        rd_st(8'h00);
        // Memory read: address only, no output
        i_sfcfe_spi_master_model.oe_hits = 0;
        run_frame(1'b0, {`SFCFE_OP_MEM_READ, 8'hff, 8'hff, 8'h00}, 4);
        chk_cmd(sfcfe_pkg::CMD_MEM_READ, cmd_o);
        chk_val(16'h07ff, {5'h00, addr_o});
        // Unknown op-code then a status op-code byte
        run_frame(1'b1, {8'ha5, `SFCFE_OP_STAT_READ, 16'h0}, 3);
        chk_cmd(sfcfe_pkg::CMD_UNKNOWN, cmd_o);
        chk_val(16'h0000, i_sfcfe_spi_master_model.oe_hits[15:0]);
        chk_val(16'h0000, i_sfcfe_spi_master_model.oe_idle[15:0]);
        complete_run();
    end
endmodule : spi_fram_command_front_end_tb_top
